// File: chmc_defs.vh
`ifndef CHMC_DEFS_VH
`define CHMC_DEFS_VH

// ----------------------------------------
// clock output mode field
// ----------------------------------------
`define CHMC_CLKSEL_HI_BIT     1
`define CHMC_CLKSEL_LO_BIT     0
`define CHMC_CLKSEL_NORMAL     2'h0
`define CHMC_CLKSEL_INHIBIT    2'h3

// ----------------------------------------
// states
// ----------------------------------------
`define CHMC_ST_RUN            2'h0
`define CHMC_ST_FILL           2'h1
`define CHMC_ST_HALT           2'h2

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define CHMC_PRIO_W            3
`define CHMC_RST_STATE         2'h0

`endif

// File: chmc_halt_ctrl.v
`include "chmc_defs.vh"
module chmc_halt_ctrl #(
  parameter PRIO_W = `CHMC_PRIO_W
) (
  input  wire              clk_i,
  input  wire              rst_b_i,
  input  wire              halt_exec_i,
  input  wire              prefetch_full_i,
  input  wire              nmi_pin_i,
  input  wire              mi_req_i,
  input  wire              mi_masked_i,
  input  wire [PRIO_W-1:0] mi_prio_i,
  input  wire              in_isr_i,
  input  wire              isr_is_nmi_i,
  input  wire [PRIO_W-1:0] isr_prio_i,
  input  wire              interrupts_enabled_state_i,
  input  wire              clock_out_disable_high_bit_i,
  input  wire              clock_out_disable_low_bit_i,
  output reg               cpu_clk_en_o,
  output reg               periph_clk_en_o,
  output reg               osc_pll_en_o,
  output reg               fetch_en_o,
  output reg               exec_freeze_o,
  output reg               clock_output_pin_o,
  output reg               halted_o,
  output reg               wake_o,
  output reg               wake_ack_o,
  output reg               wake_nmi_o,
  output reg               wake_pend_o,
  output reg               wake_next_insn_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg  [2:0] nmi_sync_r;
  wire       nmi_edge;

  // nmi is edge triggered: a pin held high wakes the cpu only once
  always @(posedge clk_i) begin
    if (!rst_b_i)
      nmi_sync_r <= 3'h0;
    else
      nmi_sync_r <= {nmi_sync_r[1:0], nmi_pin_i};
  end

  // edge detect reads only stages two and three
  assign nmi_edge = nmi_sync_r[1] & ~nmi_sync_r[2];

  // ----------------------------------------
  // strap synchroniser
  // ----------------------------------------
  reg  [1:0] sel_s1_r;
  reg  [1:0] sel_s2_r;

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      sel_s1_r <= 2'h0;
      sel_s2_r <= 2'h0;
    end else begin
      sel_s1_r <= {clock_out_disable_high_bit_i, clock_out_disable_low_bit_i};
      sel_s2_r <= sel_s1_r;
    end
  end

  // ----------------------------------------
  // wake decode
  // ----------------------------------------
  wire mi_wake  = mi_req_i & ~mi_masked_i;
  wire any_wake = nmi_edge | mi_wake;
  // nmi outranks any maskable service; nothing outranks an nmi in service
  wire nmi_high = ~(in_isr_i & isr_is_nmi_i);
  wire mi_high  = ~in_isr_i | (~isr_is_nmi_i & (mi_prio_i < isr_prio_i));
  reg  ack_nxt;
  reg  nmi_nxt;
  reg  pend_nxt;
  reg  next_nxt;

  always @* begin
    ack_nxt  = 1'b0;
    nmi_nxt  = 1'b0;
    pend_nxt = 1'b0;
    next_nxt = 1'b0;
    if (nmi_edge) begin
      if (nmi_high) begin
        ack_nxt = 1'b1;
        nmi_nxt = 1'b1;
      end else begin
        pend_nxt = 1'b1;
        next_nxt = 1'b1;
      end
    end else if (mi_wake) begin
      if (interrupts_enabled_state_i && mi_high) begin
        ack_nxt = 1'b1;
      end else begin
        pend_nxt = 1'b1;
        next_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // halt sequencer
  // ----------------------------------------
  reg [1:0] state_r;
  reg [1:0] state_nxt;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `CHMC_ST_RUN: begin
        if (halt_exec_i)
          state_nxt = `CHMC_ST_FILL;
      end
      `CHMC_ST_FILL: begin
        if (any_wake)
          state_nxt = `CHMC_ST_RUN;
        else if (prefetch_full_i)
          state_nxt = `CHMC_ST_HALT;
      end
      `CHMC_ST_HALT: begin
        if (any_wake)
          state_nxt = `CHMC_ST_RUN;
      end
      default: state_nxt = `CHMC_RST_STATE;
    endcase
  end

  wire halting = (state_nxt == `CHMC_ST_HALT);
  wire filling = (state_nxt == `CHMC_ST_FILL);
  wire waking  = (state_r != `CHMC_ST_RUN) & any_wake;

  // ----------------------------------------
  // clock output divider
  // ----------------------------------------
  // pin runs at half the system clock; inhibit parks it low
  reg clock_output_pin_r;
  always @(posedge clk_i) begin
    if (!rst_b_i)
      clock_output_pin_r <= 1'b0;
    else if (sel_s2_r == `CHMC_CLKSEL_INHIBIT)
      clock_output_pin_r <= 1'b0;
    else
      clock_output_pin_r <= ~clock_output_pin_r;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // only the cpu clock is ever gated; generator and peripherals run on
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      cpu_clk_en_o    <= 1'h1;
      periph_clk_en_o <= 1'h1;
      osc_pll_en_o    <= 1'h1;
    end else begin
      cpu_clk_en_o    <= ~halting;
      periph_clk_en_o <= 1'h1;
      osc_pll_en_o    <= 1'h1;
    end
  end

  // ----------------------------------------
  // fetch and execution control
  // ----------------------------------------
  // fetch stays on through fill so the queue can top up while execution is frozen
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      fetch_en_o    <= 1'h1;
      exec_freeze_o <= 1'h0;
    end else begin
      fetch_en_o    <= ~halting;
      exec_freeze_o <= halting | filling;
    end
  end

  // ----------------------------------------
  // halt status and clock output pin
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      // reset path is the ordinary one: no halt state survives it
      state_r            <= `CHMC_RST_STATE;
      halted_o           <= 1'h0;
      clock_output_pin_o <= 1'h0;
    end else begin
      state_r            <= state_nxt;
      halted_o           <= halting;
      clock_output_pin_o <= clock_output_pin_r;
    end
  end

  // ----------------------------------------
  // wake outcome pulses
  // ----------------------------------------
  // qualified by waking, so a request seen while running leaves no pulse
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      wake_o           <= 1'h0;
      wake_ack_o       <= 1'h0;
      wake_nmi_o       <= 1'h0;
      wake_pend_o      <= 1'h0;
      wake_next_insn_o <= 1'h0;
    end else begin
      wake_o           <= waking;
      wake_ack_o       <= waking & ack_nxt;
      wake_nmi_o       <= waking & nmi_nxt;
      wake_pend_o      <= waking & pend_nxt;
      wake_next_insn_o <= waking & next_nxt;
    end
  end

endmodule // chmc_halt_ctrl

// File: chmc_cpu_model.sv
module chmc_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       freeze_i,
  input  wire logic [3:0] fill_cyc_i,
  output wire logic       prefetch_full_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  // ----------------------------------------
  // queue keeps filling for fill_cyc_i cycles
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_b_i || !freeze_i) cnt_r <= 4'h0;
    else if (cnt_r != fill_cyc_i) cnt_r <= cnt_r + 4'h1;
  end
  assign prefetch_full_o = freeze_i && (cnt_r == fill_cyc_i);
endmodule // chmc_cpu_model

// File: chmc_halt_ctrl_chk.sv
module chmc_halt_chk (
  input wire logic clk_i, rst_b_i, halt_exec_i, prefetch_full_i, mi_req_i, mi_masked_i,
  input wire logic interrupts_enabled_state_i, clock_out_disable_high_bit_i,
  input wire logic clock_out_disable_low_bit_i, cpu_clk_en_o, periph_clk_en_o,
  input wire logic osc_pll_en_o, fetch_en_o, exec_freeze_o, clock_output_pin_o, halted_o,
  input wire logic wake_o, wake_ack_o, wake_nmi_o, wake_pend_o, wake_next_insn_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_clocks_kept: assert property (periph_clk_en_o && osc_pll_en_o)
    else $error("clock stopped");
  a_halt_gates_cpu: assert property (halted_o == !cpu_clk_en_o)
    else $error("cpu gate");
  a_halt_frozen: assert property (halted_o |-> exec_freeze_o && !fetch_en_o)
    else $error("not frozen");
  a_enter_fill: assert property (halt_exec_i && !exec_freeze_o |=> exec_freeze_o)
    else $error("no entry");
  a_full_first: assert property ($rose(halted_o) |-> $past(prefetch_full_i))
    else $error("early halt");
  a_wake_clock: assert property (wake_o |-> cpu_clk_en_o && !halted_o)
    else $error("clock not back");
  a_one_outcome: assert property (wake_o |-> wake_ack_o != wake_pend_o
    && wake_pend_o == wake_next_insn_o) else $error("outcome");
  a_mi_wakes: assert property (halted_o && mi_req_i && !mi_masked_i |=> wake_o)
    else $error("no wake");
  a_off_next: assert property (wake_o && !wake_nmi_o &&
    !$past(interrupts_enabled_state_i) |-> wake_next_insn_o) else $error("taken");
  a_nmi_branch: assert property (wake_nmi_o |-> wake_ack_o)
    else $error("nmi");
  a_inhibit_low: assert property ((clock_out_disable_high_bit_i &&
    clock_out_disable_low_bit_i)[*5] |-> !clock_output_pin_o) else $error("pin");
  c_ack: cover property (wake_o && wake_ack_o);
  c_pend: cover property (wake_o && wake_pend_o);
  c_halt: cover property ($rose(halted_o));
  c_nmi: cover property (wake_o && wake_nmi_o);
endmodule // chmc_halt_chk
bind chmc_halt_ctrl chmc_halt_chk u_chk (.*);

// File: test_chmc_halt_ctrl.sv
module test_chmc_halt_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_b_i = 0, halt_exec_i = 0, nmi_pin_i = 0, mi_req_i = 0, mi_masked_i = 0;
  logic in_isr_i = 0, isr_is_nmi_i = 0, interrupts_enabled_state_i = 0;
  logic clock_out_disable_high_bit_i = 0, clock_out_disable_low_bit_i = 0, prefetch_full_i;
  logic [2:0] mi_prio_i = 0, isr_prio_i = 0;
  logic [3:0] fill = 0;
  logic cpu_clk_en_o, periph_clk_en_o, osc_pll_en_o, fetch_en_o, exec_freeze_o, halted_o;
  logic clock_output_pin_o, wake_o, wake_ack_o, wake_nmi_o, wake_pend_o, wake_next_insn_o;
  int failures = 0, tests_run = 0, cycles = 0;
  always #2.5 clk_i = ~clk_i;
  chmc_halt_ctrl u_dut (.*);
  chmc_cpu_model u_cpu (.clk_i(clk_i), .rst_b_i(rst_b_i), .freeze_i(exec_freeze_o),
    .fill_cyc_i(fill), .prefetch_full_o(prefetch_full_i));
  task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
    tests_run++;
    if (exp !== got) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic enter_halt(input logic [3:0] f);
    int n;
    @(posedge clk_i) begin fill <= f; halt_exec_i <= 1; end
    @(posedge clk_i) halt_exec_i <= 0;
    @(negedge clk_i) chk("fill", 4'h1, {2'h0, halted_o, exec_freeze_o});
    for (n = 0; n < 20 && halted_o !== 1; n++) @(negedge clk_i);
    chk("halt", 4'hA, {halted_o, cpu_clk_en_o, exec_freeze_o, fetch_en_o});
    chk("clock gen", 4'h3, {2'h0, periph_clk_en_o, osc_pll_en_o});
  endtask
  task automatic wake_case(logic nmi, ie, isr, isn, logic [2:0] ip, rp, logic [3:0] exp);
    int n;
    enter_halt(4'h1);
    @(posedge clk_i) begin
      interrupts_enabled_state_i <= ie; in_isr_i <= isr; isr_is_nmi_i <= isn;
      isr_prio_i <= ip; mi_prio_i <= rp; nmi_pin_i <= nmi; mi_req_i <= !nmi;
    end
    for (n = 0; n < 8 && wake_o !== 1; n++) @(negedge clk_i);
    chk("wake", exp, {wake_ack_o, wake_nmi_o, wake_pend_o, wake_next_insn_o});
    chk("cpu clock", 4'h1, {3'h0, cpu_clk_en_o});
    @(posedge clk_i) begin nmi_pin_i <= 0; mi_req_i <= 0; end
  endtask
  task automatic masked_case;
    logic seen;
    seen = 0;
    enter_halt(4'h0);
    @(posedge clk_i) begin mi_masked_i <= 1; mi_req_i <= 1; end
    repeat (6) @(negedge clk_i) seen |= wake_o;
    chk("masked", 4'h1, {2'h0, seen, halted_o});
    @(posedge clk_i) mi_masked_i <= 0;
    repeat (3) @(negedge clk_i) seen |= wake_o;
    chk("unmasked", 4'h2, {2'h0, seen, halted_o});
    @(posedge clk_i) mi_req_i <= 0;
  endtask
  task automatic clock_output_pin_case(logic [1:0] sel, logic exp);
    logic seen;
    seen = 0;
    @(posedge clk_i) {clock_out_disable_high_bit_i, clock_out_disable_low_bit_i} <= sel;
    repeat (6) @(negedge clk_i);
    repeat (8) @(negedge clk_i) seen |= clock_output_pin_o;
    chk("clock out", {3'h0, exp}, {3'h0, seen});
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      finish_test;
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1;
    enter_halt(4'h5);
    clock_output_pin_case(2'h0, 1'b1);
    clock_output_pin_case(2'h1, 1'b1);
    clock_output_pin_case(2'h3, 1'b0);
    @(posedge clk_i) rst_b_i <= 0;
    @(posedge clk_i) rst_b_i <= 1;
    @(negedge clk_i);
    chk("reset", 4'h4, {halted_o, cpu_clk_en_o, exec_freeze_o, wake_o});
    masked_case;
    wake_case(0, 1, 0, 0, 3'h0, 3'h3, 4'h8);
    wake_case(0, 0, 0, 0, 3'h0, 3'h3, 4'h3);
    wake_case(0, 1, 1, 0, 3'h2, 3'h5, 4'h3);
    wake_case(0, 1, 1, 0, 3'h5, 3'h2, 4'h8);
    wake_case(1, 0, 1, 0, 3'h1, 3'h0, 4'hC);
    wake_case(1, 1, 0, 0, 3'h0, 3'h0, 4'hC);
    wake_case(1, 1, 1, 1, 3'h0, 3'h0, 4'h3);
    wake_case(0, 1, 1, 1, 3'h7, 3'h0, 4'h3);
    finish_test;
  end
endmodule // test_chmc_halt_ctrl
